// ---- include/ddps_pkg.sv ----
/*
  Shared constants for the demultiplexer port sequencer: word sizes, port counts,
  start-up discard counts, buffer sizing and the core clock figures.
  Assumes nothing of its surroundings; every user names items as ddps_pkg::name.
*/
package ddps_pkg;
  // core clock figures
  localparam int CLK_MHZ = 250;
  localparam int CLK_PERIOD_NS = 4;
  // word and port geometry
  localparam int WORD_W = 10;
  localparam int PORT_N = 8;
  localparam int SEL_W = 3;
  localparam logic [2:0] LAST_PORT_1TO8 = 3'h7;
  localparam logic [2:0] LAST_PORT_1TO4 = 3'h3;
  localparam logic [2:0] FIRST_PORT = 3'h0;
  // buffer between capture and sequencer, one skip flag above the word
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = WORD_W + 1;
  localparam int SKIP_BIT = WORD_W;
  // words dropped after a clear, by start condition
  localparam logic [1:0] DISCARD_1TO8_FAST = 2'h2;
  localparam logic [1:0] DISCARD_1TO4_FAST = 2'h1;
  localparam logic [1:0] DISCARD_SLOW = 2'h1;
  // narrow words keep the upper eight bits, the two low bits read as zero
  localparam logic [9:0] NARROW_MASK = 10'h3FC;
  // self-test generator start value and step
  localparam logic [9:0] BIST_SEED = 10'h000;
  localparam logic [9:0] BIST_STEP = 10'h001;
  // pipeline depth of a first-port word, in input words
  localparam int PIPE_1TO8 = 7;
  localparam int PIPE_1TO4 = 3;
  typedef enum logic [0:0] {DDPS_ST_CLEAR, DDPS_ST_RUN} ddps_state_t;
endpackage

// ---- include/ddps_stream_if.sv ----
/*
  Valid/ready word stream between the capture front end, the buffer and the
  port sequencer. Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface ddps_stream_if #(
  parameter int W = 11
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- verilog/ddps_fifo.sv ----
/*
  Synchronous word buffer with valid/ready on both sides and a flush.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module ddps_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic flush_i,
  ddps_stream_if.snk push,
  ddps_stream_if.src pop
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  // full and empty come straight from the occupancy count
  assign push.ready = (cnt_q != (AW+1)'(DEPTH)) && !flush_i;
  assign pop.valid = (cnt_q != '0);
  assign pop.data = mem_q[rd_q];
  assign do_push = push.valid && push.ready;
  assign do_pop = pop.valid && pop.ready;

  // storage is written without reset, contents are guarded by the count
  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem_q[wr_q] <= push.data;
    end
  end

  // pointers and count; a flush empties the buffer in one edge
  always_ff @(posedge clock_i) begin
    if (rst_i || flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (do_pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// ---- verilog/ddps_top.sv ----
/*
  Port sequencer of a 1:4 / 1:8 word demultiplexer. Words from a converter are
  caught on the converter's own strobe, buffered, and distributed over the first four
  or all eight 10-bit output ports; a full set is latched and announced by one strobe.
  Assumes every pin input is asynchronous to clock_i and that the input
  strobe runs well below the core clock, so each edge is seen after two
  synchroniser stages.
*/
`timescale 1ns/10ps
module ddps_top #(
  parameter int WORD_W = 10,
  parameter int PORT_N = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic input_sample_clock_i,
  input wire logic [WORD_W-1:0] word_i,
  input wire logic async_clear_i,
  input wire logic resync_pulse_i,
  input wire logic clock_rate_type_select_i,
  input wire logic split_ratio_select_i,
  input wire logic word_width_select_i,
  input wire logic self_test_n_i,
  input wire logic high_rate_start_i,
  input wire logic drain_hold_i,
  output logic [PORT_N*WORD_W-1:0] port_data_o,
  output logic output_valid_strobe_o,
  output logic [2:0] port_select_o,
  output logic overflow_o
);
  localparam int CTL_N = 7;
  localparam int FW = WORD_W + 1;

  // index of the last active port for the chosen ratio
  function automatic logic [2:0] last_port(input logic ratio_4);
    last_port = ratio_4 ? ddps_pkg::LAST_PORT_1TO4 : ddps_pkg::LAST_PORT_1TO8;
  endfunction

  // words dropped after a clear for the start condition in force
  function automatic logic [1:0] discard_count(input logic fast, input logic ratio_4);
    if (!fast) begin
      discard_count = ddps_pkg::DISCARD_SLOW;
    end else if (ratio_4) begin
      discard_count = ddps_pkg::DISCARD_1TO4_FAST;
    end else begin
      discard_count = ddps_pkg::DISCARD_1TO8_FAST;
    end
  endfunction

  logic [CTL_N-1:0] ctl_s1_q;
  logic [CTL_N-1:0] ctl_s2_q;
  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_s3_q;
  logic [WORD_W-1:0] dat_s1_q;
  logic [WORD_W-1:0] dat_s2_q;
  logic rsy_s3_q;
  logic clear_lvl;
  logic resync_lvl;
  logic rate_full;
  logic ratio_4;
  logic width_10;
  logic bist_on;
  logic fast_start;
  logic rise;
  logic fall;
  logic cap;
  logic resync_edge;
  logic [WORD_W-1:0] bist_q;
  logic [WORD_W-1:0] src_word;
  logic [1:0] disc_q;
  logic ovf_q;
  ddps_pkg::ddps_state_t state_q;
  logic [2:0] sel_q;
  logic [WORD_W-1:0] slot_q [PORT_N];
  logic [PORT_N*WORD_W-1:0] out_q;
  logic stb_q;
  logic pop_now;
  logic set_done;
  logic flush;

  ddps_stream_if #(.W(FW)) cap_if ();
  ddps_stream_if #(.W(FW)) seq_if ();

  // two flip-flops on every control pin level before any logic looks at it; drain_hold_i is used as it comes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctl_s1_q <= '0;
      ctl_s2_q <= '0;
    end else begin
      ctl_s1_q <= {high_rate_start_i, self_test_n_i, word_width_select_i,
                   split_ratio_select_i, clock_rate_type_select_i,
                   resync_pulse_i, async_clear_i};
      ctl_s2_q <= ctl_s1_q;
    end
  end

  // strobe and data share the same depth so the word lines up with its edge;
  // strobe stages follow the pin through reset, so an idle-high pin is no edge
  always_ff @(posedge clock_i) begin
    clk_s1_q <= input_sample_clock_i;
    clk_s2_q <= clk_s1_q;
    clk_s3_q <= clk_s2_q;
    if (rst_i) begin
      dat_s1_q <= '0;
      dat_s2_q <= '0;
      rsy_s3_q <= 1'b0;
    end else begin
      dat_s1_q <= word_i;
      dat_s2_q <= dat_s1_q;
      rsy_s3_q <= ctl_s2_q[1];
    end
  end

  assign clear_lvl = ctl_s2_q[0];
  assign resync_lvl = ctl_s2_q[1];
  assign rate_full = ctl_s2_q[2];
  assign ratio_4 = ctl_s2_q[3];
  assign width_10 = ctl_s2_q[4];
  assign bist_on = !ctl_s2_q[5];
  assign fast_start = ctl_s2_q[6];

  // words taken on the converter strobe
  assign rise = clk_s2_q && !clk_s3_q;
  assign fall = !clk_s2_q && clk_s3_q;
  // at half rate either edge counts, so phase does not matter; at full rate only rising edges count
  assign cap = rate_full ? rise : (rise || fall);

  // resync acts on its rising edge only
  assign resync_edge = resync_lvl && !rsy_s3_q;

  // pattern generator, held at its seed while the control is high
  always_ff @(posedge clock_i) begin
    if (rst_i || !bist_on) begin
      bist_q <= WORD_W'(ddps_pkg::BIST_SEED);
    end else if (cap) begin
      bist_q <= bist_q + WORD_W'(ddps_pkg::BIST_STEP);
    end
  end

  // narrow words lose two low bits
  always_comb begin
    src_word = bist_on ? bist_q : dat_s2_q;
    if (!width_10) begin
      src_word = src_word & WORD_W'(ddps_pkg::NARROW_MASK);
    end
  end

  // start-up discard counter, loaded for as long as the clear is held
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      disc_q <= '0;
    end else if (clear_lvl) begin
      // one lost in a slow start
      disc_q <= discard_count(fast_start, ratio_4);
    end else if (cap && cap_if.ready && disc_q != 2'h0) begin
      disc_q <= disc_q - 2'h1;
    end
  end

  // discarded words still travel as skip tokens so the selector steps past them
  assign cap_if.valid = cap && !clear_lvl;
  assign cap_if.data = {disc_q != 2'h0, src_word};

  // a word that finds the buffer full is dropped and reported; sticky until reset or a clear
  always_ff @(posedge clock_i) begin
    if (rst_i || clear_lvl) begin
      ovf_q <= 1'b0;
    end else if (cap_if.valid && !cap_if.ready) begin
      ovf_q <= 1'b1;
    end
  end

  // resync flushes the queue so selection restarts in step with input
  assign flush = clear_lvl || resync_edge;

  ddps_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .push(cap_if),
    .pop(seq_if)
  );

  // the sequencer is the only drain; a hold from downstream backs up the buffer
  assign seq_if.ready = (state_q == ddps_pkg::DDPS_ST_RUN) && !drain_hold_i && !flush;
  assign pop_now = seq_if.valid && seq_if.ready;
  assign set_done = pop_now && (sel_q == last_port(ratio_4));

  // clear holds the sequencer while high
  always_ff @(posedge clock_i) begin
    if (rst_i || clear_lvl) begin
      state_q <= ddps_pkg::DDPS_ST_CLEAR;
    end else begin
      case (state_q)
        ddps_pkg::DDPS_ST_CLEAR: state_q <= ddps_pkg::DDPS_ST_RUN;
        ddps_pkg::DDPS_ST_RUN: state_q <= ddps_pkg::DDPS_ST_RUN;
        default: state_q <= ddps_pkg::DDPS_ST_CLEAR;
      endcase
    end
  end

  // port selector; a restart drops the half-built set without touching outputs
  always_ff @(posedge clock_i) begin
    if (rst_i || clear_lvl) begin
      sel_q <= ddps_pkg::FIRST_PORT;
    end else if (resync_edge) begin
      // restart at first port, no update
      sel_q <= ddps_pkg::FIRST_PORT;
    end else if (pop_now) begin
      // step in order, wrap after last
      // first port word waits until last port
      sel_q <= set_done ? ddps_pkg::FIRST_PORT : sel_q + 3'h1;
    end
  end

  // staging slots; skip tokens advance the selector but store nothing
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < PORT_N; i++) begin
        slot_q[i] <= '0;
      end
    end else if (pop_now && !seq_if.data[ddps_pkg::SKIP_BIT]) begin
      slot_q[sel_q] <= seq_if.data[WORD_W-1:0];
    end
  end

  // outputs update only at last port
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      out_q <= '0;
    end else if (set_done) begin
      for (int i = 0; i < PORT_N; i++) begin
        if (i == int'(sel_q)) begin
          out_q[i*WORD_W +: WORD_W] <= seq_if.data[WORD_W-1:0];
        end else if (i < int'(sel_q)) begin
          out_q[i*WORD_W +: WORD_W] <= slot_q[i];
        end
      end
    end
  end

  // one-cycle strobe with each latched set
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stb_q <= 1'b0;
    end else begin
      stb_q <= set_done && !clear_lvl && !resync_edge;
    end
  end

  // selector view for debug, one edge behind the selector itself
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      port_select_o <= ddps_pkg::FIRST_PORT;
    end else begin
      port_select_o <= sel_q;
    end
  end

  assign port_data_o = out_q;
  assign output_valid_strobe_o = stb_q;
  assign overflow_o = ovf_q;
endmodule

// ---- sim/ddps_assertions.sv ----
/*
  Checker for the port sequencer top, bound by the statement at its foot.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module ddps_assertions #(
  parameter int WORD_W = 10,
  parameter int PORT_N = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic async_clear_i,
  input wire logic split_ratio_select_i,
  input wire logic [PORT_N*WORD_W-1:0] port_data_o,
  input wire logic output_valid_strobe_o,
  input wire logic [2:0] port_select_o,
  input wire logic overflow_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [2:0] clr_age_q;
  // cycles since clear fell, saturating once the pin synchroniser has caught up
  always_ff @(posedge clock_i) begin
    if (rst_i || async_clear_i) clr_age_q <= 3'h0;
    else if (clr_age_q != 3'h7) clr_age_q <= clr_age_q + 3'h1;
  end
  strobe_spacing_a: assert property (
    output_valid_strobe_o |=> !output_valid_strobe_o [*3]) else $error("strobe too close");
  latch_then_strobe_a: assert property (
    $changed(port_data_o) |-> output_valid_strobe_o) else $error("data moved without strobe");
  reset_outputs_a: assert property (disable iff (1'b0)
    rst_i |=> port_data_o == '0 && !output_valid_strobe_o && port_select_o == 3'h0
      && !overflow_o) else $error("outputs not cleared by reset");
  upper_ports_hold_a: assert property (
    split_ratio_select_i [*8] |-> $stable(port_data_o[PORT_N*WORD_W-1:4*WORD_W]))
    else $error("unused port changed in 1:4");
  ratio_range_a: assert property (
    split_ratio_select_i [*4] |-> port_select_o <= 3'h3) else $error("selector beyond port 3");
  sel_step_a: assert property (
    $changed(port_select_o) |-> port_select_o == 3'h0
      || port_select_o == 3'($past(port_select_o) + 3'h1)) else $error("selector skipped");
  clear_hold_a: assert property (
    async_clear_i [*6] |-> port_select_o == 3'h0) else $error("selector moved in clear");
  overflow_sticky_a: assert property (
    overflow_o && clr_age_q == 3'h7 |=> overflow_o) else $error("overflow dropped");
  cover property (output_valid_strobe_o);
  cover property ($rose(overflow_o));
  cover property (split_ratio_select_i && output_valid_strobe_o);
endmodule

bind ddps_top ddps_assertions #(.WORD_W(WORD_W), .PORT_N(PORT_N)) u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .async_clear_i(async_clear_i),
  .split_ratio_select_i(split_ratio_select_i), .port_data_o(port_data_o),
  .output_valid_strobe_o(output_valid_strobe_o), .port_select_o(port_select_o),
  .overflow_o(overflow_o));

// ---- sim/ddps_adc_model.sv ----
/*
  Converter model: sends a counted burst of words on its own strobe.
  Assumes go_i pulses for one cycle while busy_o is low.
*/
`timescale 1ns/10ps
module ddps_adc_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic full_rate_i,
  input wire logic [9:0] base_i,
  input wire logic [5:0] count_i,
  output logic strobe_o,
  output logic [9:0] word_o,
  output logic busy_o
);
  logic [2:0] ph_q;
  logic [5:0] left_q;
  logic [9:0] val_q;
  // edges every eight cycles; words move mid-gap so they stand still around each edge
  // words aligned to strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      strobe_o <= 1'b0;
      word_o <= 10'h000;
    end else if (go_i) begin
      busy_o <= 1'b1;
      ph_q <= 3'h4;
      left_q <= count_i;
      val_q <= base_i - 10'h001;
    end else if (busy_o) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h0) begin
        strobe_o <= ~strobe_o;
        if (!full_rate_i || !strobe_o) left_q <= left_q - 6'h01;
      end
      if (ph_q == 3'h4 && left_q == 6'h00) begin
        // released: never leave a stale word on the pins
        busy_o <= 1'b0;
        word_o <= ~word_o;
        if (full_rate_i) strobe_o <= 1'b0;
      end else if (ph_q == 3'h4 && (!full_rate_i || !strobe_o)) begin
        val_q <= val_q + 10'h001;
        word_o <= val_q + 10'h001;
      end
    end
  end
endmodule

// ---- sim/ddps_top_tb_top.sv ----
/*
  Bench for the port sequencer: random bursts in every mode, resync, self-test
  and overflow. Assumes the checker is bound by its own file.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module ddps_top_tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic clr = 1'b0, rsy = 1'b0, full = 1'b1, r14 = 1'b0, wide = 1'b1, st_n = 1'b1;
  logic fast = 1'b0, hold = 1'b0, go = 1'b0, smp, busy, vstb, ovf;
  logic [5:0] n_w = 6'h00;
  logic [9:0] base = 10'h000, wrd;
  logic [9:0] w [8], o [8];
  logic [2:0] psel;
  logic [79:0] pdat;
  bit k [8], ko [8];
  int sel = 0, nexp = 0, n_strb = 0, err_total = 0, n_tests = 0;
  integer seed = 5;

  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) if (vstb === 1'b1) n_strb++;

  ddps_adc_model adc (.clock_i(clock_i), .rst_i(rst_i), .go_i(go), .full_rate_i(full),
    .base_i(base), .count_i(n_w), .strobe_o(smp), .word_o(wrd), .busy_o(busy));
  ddps_top dut (.clock_i(clock_i), .rst_i(rst_i), .input_sample_clock_i(smp), .word_i(wrd),
    .async_clear_i(clr), .resync_pulse_i(rsy), .clock_rate_type_select_i(full),
    .split_ratio_select_i(r14), .word_width_select_i(wide), .self_test_n_i(st_n),
    .high_rate_start_i(fast), .drain_hold_i(hold), .port_data_o(pdat),
    .output_valid_strobe_o(vstb), .port_select_o(psel), .overflow_o(ovf));

  // predict one word at the selector; a skipped slot keeps an unknown value
  function automatic void feed(logic [9:0] v, bit skip);
    if (skip) k[sel] = 1'b0;
    else begin
      w[sel] = wide ? v : (v & ddps_pkg::NARROW_MASK);
      k[sel] = 1'b1;
    end
    if (sel == (r14 ? 3 : 7)) begin
      o = w;
      ko = k;
      nexp++;
      sel = 0;
    end else sel++;
  endfunction

  task automatic pump(int n);
    go <= 1'b1;
    n_w <= 6'(n);
    @(posedge clock_i) go <= 1'b0;
    @(posedge clock_i);
    for (int t = 0; t < 2000 && busy; t++) @(posedge clock_i);
    repeat (12) @(posedge clock_i);
  endtask

  task automatic send(int n, int d);
    n_strb = 0;
    nexp = 0;
    for (int i = 0; i < n; i++) feed(base + 10'(i), i < d);
    pump(n);
    `CHK(n_strb, nexp)
    for (int p = 0; p < 8; p++) if (ko[p]) `CHK(pdat[p*10 +: 10], o[p])
  endtask

  task automatic clear();
    clr <= 1'b1;
    repeat (6) @(posedge clock_i);
    clr <= 1'b0;
    sel = 0;
    repeat (6) @(posedge clock_i);
  endtask

  task automatic resync();
    rsy <= 1'b1;
    repeat (4) @(posedge clock_i);
    rsy <= 1'b0;
    sel = 0;
    repeat (6) @(posedge clock_i);
    `CHK(psel, 3'h0)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    int part;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    // every ratio, rate, start speed and width, words counting up from a random base
    for (int i = 0; i < 16; i++) begin
      {wide, fast, full, r14} <= 4'(i);
      base <= 10'($random(seed));
      @(posedge clock_i);
      clear();
      send(r14 ? 8 : 16, fast ? (r14 ? 1 : 2) : 1);
      part = 1 + ($unsigned($random(seed)) % (r14 ? 3 : 7));
      send(part, 0);
      resync();
      send(r14 ? 4 : 8, 0);
      $display("mode test %0d done", i);
    end
    {st_n, r14, full, fast, wide} <= 5'b01101;
    base <= 10'h000;
    @(posedge clock_i);
    clear();
    send(4, 1);
    $display("self-test done");
    // stall the sequencer so the buffer overflows
    st_n <= 1'b1;
    hold <= 1'b1;
    @(posedge clock_i);
    clear();
    pump(20);
    `CHK(ovf, 1'b1)
    hold <= 1'b0;
    repeat (100) @(posedge clock_i);
    clear();
    `CHK(ovf, 1'b0)
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK({pdat, vstb, psel, ovf}, 85'h0)
    $display("overflow and reset done");
    results();
  end

  // the tests take about 6000 cycles; give them ten times that
  initial begin
    repeat (60000) @(posedge clock_i);
    err_total++;
    results();
  end
endmodule
